//--- logic/udb_data_in.sv
// data-in burst sender: streams fifo words to the host on strobe edges
// assumes host pins arrive asynchronously and pass a two-flop stage;
// the surrounding pad logic resolves output enables into wire levels
`timescale 1ns/1ns
`include "udb_regs.svh"
module udb_data_in (
	input wire logic REF_CLK_I, // 100 MHz core clock
	input wire logic RST_I, // synchronous reset, high
	input wire logic [2:0] MODE_I, // transfer mode 0..4
	input wire logic XFER_REQ_I, // user wants a burst, level
	input wire logic PAUSE_I, // user withholds strobes, level
	input wire logic [15:0] WR_DATA_I, // word to send
	input wire logic WR_VALID_I, // word offered
	output logic WR_READY_O, // fifo has room
	output logic DMARQ_O, // burst request, high
	input wire logic DMACK_N_I, // host ack, low
	input wire logic STOP_I, // host stop, high
	input wire logic HDMARDY_N_I, // host ready, low
	output logic DSTROBE_O, // data strobe level
	output logic DSTROBE_OE_O, // strobe driven, high
	input wire logic [15:0] DD_I, // bus in
	output logic [15:0] DD_O, // bus out
	output logic DD_OE_O, // bus driven, high
	output logic [15:0] CRC_O, // check word from host
	output logic CRC_VALID_O, // check word fresh, pulse
	output logic BUSY_O // burst in progress, level
);
	// ----------------------------------------------------------------
	// synchronised pins
	// ----------------------------------------------------------------
	logic [18:0] pin_s; // ack_n, stop, rdy_n, bus
	logic dmack_n_s, stop_s, rdy_n_s; // synced controls
	logic [15:0] dd_s; // synced bus

	udb_sync #(.W(19)) u_sync (
		.clk_i(REF_CLK_I),
		.rst_i(RST_I),
		.d_i({DMACK_N_I, STOP_I, HDMARDY_N_I, DD_I}),
		.q_o(pin_s)
	);
	assign {dmack_n_s, stop_s, rdy_n_s, dd_s} = pin_s;

	// ----------------------------------------------------------------
	// word fifo
	// ----------------------------------------------------------------
	udb_stream_if fq ();
	udb_fifo #(.W(16), .D(16)) u_fifo (
		.clk_i(REF_CLK_I),
		.rst_i(RST_I),
		.wdata_i(WR_DATA_I),
		.wvalid_i(WR_VALID_I),
		.wready_o(WR_READY_O),
		.rd(fq.src)
	);

	// ----------------------------------------------------------------
	// per-mode cycle counts
	// ----------------------------------------------------------------
	udb_pkg::udb_cnt_t dvs_c, cyc_c, dvh_c, zio_c, zad_c; // waits
	// stop-to-request limit in cycles; an int so a delay range may use it
	localparam int LI_C = `UDB_MAX_CYC(`UDB_T_LI_PS);

	// table lookup; unlisted codes fall back to the slowest mode
	always_comb begin
		dvh_c = 8'(`UDB_MIN_CYC(`UDB_T_DVH_PS));
		zio_c = 8'(`UDB_MIN_CYC(`UDB_T_ZIORDY_PS));
		zad_c = 8'(`UDB_MIN_CYC(`UDB_T_ZAD_PS));
		unique case (MODE_I)
			3'h1: begin
				dvs_c = 8'(`UDB_MIN_CYC(`UDB_T_DVS_M1_PS));
				cyc_c = 8'(`UDB_MIN_CYC(`UDB_T_CYC_M1_PS));
			end
			3'h2: begin
				dvs_c = 8'(`UDB_MIN_CYC(`UDB_T_DVS_M2_PS));
				cyc_c = 8'(`UDB_MIN_CYC(`UDB_T_CYC_M2_PS));
			end
			3'h3: begin
				dvs_c = 8'(`UDB_MIN_CYC(`UDB_T_DVS_M3_PS));
				cyc_c = 8'(`UDB_MIN_CYC(`UDB_T_CYC_M3_PS));
			end
			3'h4: begin
				dvs_c = 8'(`UDB_MIN_CYC(`UDB_T_DVS_M4_PS));
				cyc_c = 8'(`UDB_MIN_CYC(`UDB_T_CYC_M4_PS));
			end
			default: begin
				dvs_c = 8'(`UDB_MIN_CYC(`UDB_T_DVS_M0_PS));
				cyc_c = 8'(`UDB_MIN_CYC(`UDB_T_CYC_M0_PS));
			end
		endcase
	end

	// ----------------------------------------------------------------
	// sequencer state
	// ----------------------------------------------------------------
	udb_pkg::udb_state_t st_q, st_d; // burst phase
	udb_pkg::udb_cnt_t cnt_q, cnt_d; // cycles in phase
	udb_pkg::udb_cnt_t gap_q, gap_d; // cycles since strobe edge
	logic dmarq_q, dmarq_d; // request line
	logic stb_q, stb_d; // strobe level
	logic stb_oe_q, stb_oe_d; // strobe driven
	logic dd_oe_q, dd_oe_d; // bus driven
	udb_pkg::udb_word_t dd_q, dd_d; // bus word
	udb_pkg::udb_word_t crc_q, crc_d; // host check word
	logic crc_v_q, crc_v_d; // check word pulse
	logic ack_n_q; // last synced ack, for its edge
	logic ack_v, stop_v, rdy_v, tog; // burst-qualified controls

	// ----------------------------------------------------------------
	// next state: strobe pacing, pause and stop handling
	// ----------------------------------------------------------------
	always_comb begin
		// pins mean stop and ready only inside the handshake
		ack_v = !dmack_n_s;
		stop_v = dmarq_q && ack_v && stop_s;
		rdy_v = dmarq_q && ack_v && !rdy_n_s;
		st_d = st_q;
		cnt_d = (cnt_q == 8'hff) ? cnt_q : cnt_q + 8'h01;
		gap_d = (gap_q == 8'hff) ? gap_q : gap_q + 8'h01;
		dmarq_d = dmarq_q;
		stb_d = stb_q;
		stb_oe_d = stb_oe_q;
		dd_oe_d = dd_oe_q;
		dd_d = dd_q;
		crc_d = crc_q;
		crc_v_d = 1'b0;
		fq.ready = 1'b0;
		tog = 1'b0;
		unique case (st_q)
			udb_pkg::S_IDLE: begin
				// only start with a word ready, so the first edge is prompt
				if (XFER_REQ_I && fq.valid) begin
					dmarq_d = 1'b1;
					st_d = udb_pkg::S_REQ;
				end
			end
			udb_pkg::S_REQ: begin
				if (ack_v) begin
					cnt_d = 8'h00;
					st_d = udb_pkg::S_ZIO;
				end
			end
			udb_pkg::S_ZIO: begin
				if (cnt_q >= zio_c) begin
					stb_oe_d = 1'b1;
					stb_d = 1'b1;
					st_d = udb_pkg::S_ENV;
				end
			end
			udb_pkg::S_ENV: begin
				if (ack_v && !stop_s && !rdy_n_s) begin
					cnt_d = 8'h00;
					st_d = udb_pkg::S_ZAD;
				end
			end
			udb_pkg::S_ZAD: begin
				// turnaround done: first word goes out
				if (cnt_q >= zad_c && fq.valid) begin
					fq.ready = 1'b1;
					dd_d = fq.data;
					dd_oe_d = 1'b1;
					cnt_d = 8'h00;
					st_d = udb_pkg::S_SETUP;
				end
			end
			udb_pkg::S_SETUP: begin
				if (stop_v) begin
					dmarq_d = 1'b0;
					cnt_d = 8'h00;
					st_d = udb_pkg::S_TERM;
				end else if (rdy_v && !PAUSE_I && cnt_q >= dvs_c
						&& gap_q >= cyc_c) begin
					// edge only once setup and spacing both met
					tog = 1'b1;
					stb_d = !stb_q;
					cnt_d = 8'h00;
					gap_d = 8'h00;
					st_d = udb_pkg::S_HOLD;
				end
			end
			udb_pkg::S_HOLD: begin
				if (stop_v) begin
					dmarq_d = 1'b0;
					cnt_d = 8'h00;
					st_d = udb_pkg::S_TERM;
				end else if (cnt_q >= dvh_c && fq.valid) begin
					// next word only after the hold; empty fifo pauses
					fq.ready = 1'b1;
					dd_d = fq.data;
					cnt_d = 8'h00;
					st_d = udb_pkg::S_SETUP;
				end
			end
			udb_pkg::S_TERM: begin
				// raise a negated strobe without data, release the bus
				if (!stb_q) begin
					stb_d = 1'b1;
				end
				if (cnt_q >= dvh_c) begin
					dd_oe_d = 1'b0;
				end
				if (!ack_n_q && dmack_n_s) begin
					crc_d = dd_s;
					crc_v_d = 1'b1;
					st_d = udb_pkg::S_DONE;
				end
			end
			udb_pkg::S_DONE: begin
				stb_oe_d = 1'b0;
				stb_d = 1'b0;
				dd_oe_d = 1'b0;
				gap_d = 8'hff;
				st_d = udb_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge REF_CLK_I) begin
		if (RST_I) begin
			st_q <= udb_pkg::S_IDLE;
			cnt_q <= 8'h00;
			gap_q <= 8'hff;
			dmarq_q <= 1'b0;
			stb_q <= 1'b0;
			stb_oe_q <= 1'b0;
			dd_oe_q <= 1'b0;
			dd_q <= 16'h0000;
			crc_q <= 16'h0000;
			crc_v_q <= 1'b0;
			ack_n_q <= 1'b1;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			gap_q <= gap_d;
			dmarq_q <= dmarq_d;
			stb_q <= stb_d;
			stb_oe_q <= stb_oe_d;
			dd_oe_q <= dd_oe_d;
			dd_q <= dd_d;
			crc_q <= crc_d;
			crc_v_q <= crc_v_d;
			ack_n_q <= dmack_n_s;
		end
	end

	assign DMARQ_O = dmarq_q;
	assign DSTROBE_O = stb_q;
	assign DSTROBE_OE_O = stb_oe_q;
	assign DD_O = dd_q;
	assign DD_OE_O = dd_oe_q;
	assign CRC_O = crc_q;
	assign CRC_VALID_O = crc_v_q;
	assign BUSY_O = (st_q != udb_pkg::S_IDLE);

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic first_neg_q; // strobe negated once this burst
	always_ff @(posedge REF_CLK_I) begin
		if (RST_I || st_q == udb_pkg::S_IDLE) begin
			first_neg_q <= 1'b0;
		end else if (stb_oe_q && $fell(stb_q)) begin
			first_neg_q <= 1'b1;
		end
	end

	default clocking cb @(posedge REF_CLK_I); endclocking
	default disable iff (RST_I);

	req_held_a: assert property ($fell(dmarq_q) |-> first_neg_q)
		else $error("request dropped before first strobe negation");
	stb_held_a: assert property (
		stb_oe_q && !dmack_n_s && st_q != udb_pkg::S_DONE |=> stb_oe_q)
		else $error("strobe released while ack held");
	zad_wait_a: assert property ($rose(dd_oe_q) |-> $past(cnt_q) >= zad_c)
		else $error("bus driven before turnaround");
	// data must have stood a full cycle, whatever the counter says
	setup_a: assert property (
		tog |-> cnt_q >= dvs_c && dd_oe_q && $stable(dd_q))
		else $error("strobe edge before data setup");
	spacing_a: assert property (
		tog |-> gap_q >= cyc_c ##1 !tog [*3])
		else $error("strobe edges too close");
	hold_a: assert property (
		dd_oe_q && $past(dd_oe_q) && $changed(dd_q) |-> $past(cnt_q) >= dvh_c)
		else $error("data changed inside hold");
	// three cycles of a negated ready pin reach the sync output, so the
	// last edge is then at most three cycles old, well inside the limit
	rfs_stop_a: assert property (
		HDMARDY_N_I [*3] |-> !tog)
		else $error("strobe edge after host pause");
	// stop is raised by the host during start-up too; only a stop seen
	// while words flow is a termination request
	li_drop_a: assert property (
		stop_v && (st_q == udb_pkg::S_SETUP || st_q == udb_pkg::S_HOLD)
		|-> ##[1:LI_C] !dmarq_q ##1 !dmarq_q [*2])
		else $error("request not dropped after stop");
	crc_cap_a: assert property (
		st_q == udb_pkg::S_TERM && !ack_n_q && dmack_n_s
		|=> CRC_VALID_O && CRC_O == $past(dd_s))
		else $error("check word not captured on ack edge");
	mode_a: assert property (dvs_c >= 8'h01 && cyc_c >= 8'h01)
		else $error("mode count below one cycle");

	burst_c: cover property ($rose(stb_oe_q));
	pause_c: cover property (st_q == udb_pkg::S_SETUP && rdy_n_s [*4]);
	term_c: cover property ($fell(dmarq_q));
	crc_c: cover property (CRC_VALID_O);
endmodule : udb_data_in

//--- logic/udb_regs.svh
// constants of the data-in burst sender: timing figures and derived counts
// assumes a 100 MHz core clock; every time below is in picoseconds
// What this block does
// - request held until first strobe negation
// - strobe driven after delay, held until end
// - first data driven after turnaround delay
// - first strobe negation after setup, promptly
// - each word set up before strobe edge
// - strobe edges spaced by cycle time
// - data held after each strobe edge
// - repeat words until done or paused
// - strobes stop soon after ready drops
// - device pauses by withholding strobe edges
// - burst meanings only while both asserted
// - request dropped quickly after host stop
// - check word latched on ack negation
`ifndef UDB_REGS_SVH
`define UDB_REGS_SVH

// ----------------------------------------------------------------
// clock
// ----------------------------------------------------------------
`define UDB_CLK_PS 10000

// ----------------------------------------------------------------
// sender data valid setup, per mode
// ----------------------------------------------------------------
`define UDB_T_DVS_M0_PS 72900
`define UDB_T_DVS_M1_PS 50900
`define UDB_T_DVS_M2_PS 33900
`define UDB_T_DVS_M3_PS 22600
`define UDB_T_DVS_M4_PS 9500
// sender data valid hold, all modes
`define UDB_T_DVH_PS 9000

// ----------------------------------------------------------------
// strobe cycle time per mode (plain defaults)
// ----------------------------------------------------------------
`define UDB_T_CYC_M0_PS 120000
`define UDB_T_CYC_M1_PS 100000
`define UDB_T_CYC_M2_PS 80000
`define UDB_T_CYC_M3_PS 60000
`define UDB_T_CYC_M4_PS 40000

// ----------------------------------------------------------------
// turnaround minimums and response maximums (plain defaults)
// ----------------------------------------------------------------
`define UDB_T_ZIORDY_PS 20000
`define UDB_T_ZAD_PS 20000
`define UDB_T_RFS_PS 60000
`define UDB_T_LI_PS 60000

// least time rounds up, longest rounds down
`define UDB_MIN_CYC(ps) (((ps) + `UDB_CLK_PS - 1) / `UDB_CLK_PS)
`define UDB_MAX_CYC(ps) ((ps) / `UDB_CLK_PS)

`define UDB_MODE_MAX 3'h4

`endif

//--- logic/udb_pkg.sv
// types shared by the data-in burst sender
// assumes nothing beyond the constants header
package udb_pkg;
	// ----------------------------------------------------------------
	// burst sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		S_IDLE,  // no burst
		S_REQ,   // request raised, waiting for ack
		S_ZIO,   // ack seen, waiting before driving strobe
		S_ENV,   // strobe driven, waiting for host go
		S_ZAD,   // host go seen, bus turnaround
		S_SETUP, // word on bus, waiting to toggle strobe
		S_HOLD,  // strobe toggled, holding word
		S_TERM,  // host stop seen, request dropped
		S_DONE   // ack gone, release strobe
	} udb_state_t;
	typedef logic [7:0] udb_cnt_t; // cycle counter
	typedef logic [15:0] udb_word_t; // one bus word
endpackage : udb_pkg

//--- logic/udb_stream_if.sv
// word stream between the fifo and the burst sequencer
// assumes one clock for both ends
`timescale 1ns/1ns
interface udb_stream_if;
	udb_pkg::udb_word_t data; // head word
	logic valid; // head word present
	logic ready; // consumer takes head
	modport src (output data, output valid, input ready);
	modport dst (input data, input valid, output ready);
endinterface : udb_stream_if

//--- logic/udb_sync.sv
// two-stage synchroniser for a group of pin levels
// assumes the inputs are asynchronous to clk_i
`timescale 1ns/1ns
module udb_sync #(
	parameter int W = 1
) (
	input wire logic clk_i, // core clock
	input wire logic rst_i, // synchronous reset
	input wire logic [W-1:0] d_i, // asynchronous levels
	output logic [W-1:0] q_o // synchronised levels
);
	logic [W-1:0] s1_q; // first stage, read only by second
	logic [W-1:0] s2_q; // second stage

	// ----------------------------------------------------------------
	// two flops; reset value is all ones so active-low lines idle
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= '1;
			s2_q <= '1;
		end else begin
			s1_q <= d_i;
			s2_q <= s1_q;
		end
	end
	assign q_o = s2_q;
endmodule : udb_sync

//--- logic/udb_fifo.sv
// word fifo with registered read data
// assumes writer and reader share the clock
`timescale 1ns/1ns
module udb_fifo #(
	parameter int W = 16,
	parameter int D = 16
) (
	input wire logic clk_i, // core clock
	input wire logic rst_i, // synchronous reset
	input wire logic [W-1:0] wdata_i, // word to store
	input wire logic wvalid_i, // word offered
	output logic wready_o, // room for a word
	udb_stream_if.src rd // head word out
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D]; // storage
	logic [AW-1:0] wp_q, wp_d; // write pointer
	logic [AW-1:0] rp_q, rp_d; // read pointer
	logic [AW:0] n_q, n_d; // fill count
	logic [W-1:0] dout_q, dout_d; // registered head
	logic push, pop; // accepted moves

	// ----------------------------------------------------------------
	// next pointers; head register bypasses a write to its slot
	// ----------------------------------------------------------------
	always_comb begin
		push = wvalid_i && wready_o;
		pop = rd.valid && rd.ready;
		wp_d = push ? wp_q + AW'(1) : wp_q;
		rp_d = pop ? rp_q + AW'(1) : rp_q;
		n_d = n_q + (AW+1)'(push) - (AW+1)'(pop);
		dout_d = (push && wp_q == rp_d) ? wdata_i : mem[rp_d];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wp_q <= '0;
			rp_q <= '0;
			n_q <= '0;
			dout_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			n_q <= n_d;
			dout_q <= dout_d;
		end
	end

	// storage is written without reset; contents are never read empty
	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wp_q] <= wdata_i;
		end
	end

	assign wready_o = (n_q != (AW+1)'(D));
	assign rd.valid = (n_q != '0);
	assign rd.data = dout_q;
endmodule : udb_fifo

//--- bench/udb_host_model.sv
// host side of the data-in burst handshake, behavioural
// assumes its own slow clock; device pins arrive as plain levels
`timescale 1ns/1ns
module udb_host_model (
	input wire logic hclk_i, // host clock, 125 ns
	input wire logic dmarq_i, // device request
	input wire logic dstrobe_i, // device strobe level
	input wire logic dstb_oe_i, // device drives strobe
	input wire logic [15:0] dd_i, // device bus word
	input wire logic dd_oe_i, // device drives bus
	output logic dmack_n_o, // ack, low
	output logic stop_o, // stop, high
	output logic rdy_n_o, // ready, low
	output logic [15:0] dd_o // check word or noise
);
	// ----------------------------------------------------------------
	// bench controls and measured figures
	// ----------------------------------------------------------------
	logic pause = 1'b0; // host withholds ready
	logic term = 1'b0; // host ends the burst
	logic drv = 1'b0; // host drives the check word
	logic [15:0] crc = 16'h0000; // check word to send
	logic [15:0] noise = 16'h0000; // released bus pattern
	udb_pkg::udb_word_t rx[$]; // words taken on strobe edges
	realtime t_ack, t_go, t_stop, t_edge, t_dat, t_rdy; // event times
	realtime d_oe, d_zad, d_li, sp, su, ho; // measured delays, ns
	int late = 0; // strobe edges that broke a window, and request drops without stop

	// released bus never holds the last value, so no stale word passes
	always @(posedge hclk_i) noise <= ~noise ^ 16'h0101;
	assign dd_o = drv ? crc : noise;

	// ----------------------------------------------------------------
	// timing probes on the device pins
	// ----------------------------------------------------------------
	always @(posedge dstb_oe_i) d_oe = $realtime - t_ack;
	always @(posedge dd_oe_i) d_zad = $realtime - t_go;
	// request may only fall in answer to stop
	always @(negedge dmarq_i) begin
		if (stop_o) d_li = $realtime - t_stop;
		else late++;
	end
	always @(dd_i) begin
		if (dd_oe_i && $realtime - t_edge < ho) ho = $realtime - t_edge;
		t_dat = $realtime;
	end
	// take a word on either strobe edge while the burst meanings hold
	always @(dstrobe_i) if (!dmack_n_o && !stop_o && dd_oe_i) begin
		if (rx.size() == 0 && dstrobe_i) late++;
		if ($realtime - t_edge < sp) sp = $realtime - t_edge;
		if ($realtime - t_dat < su) su = $realtime - t_dat;
		if (rdy_n_o && $realtime - t_rdy > 60.0) late++;
		rx.push_back(dd_i);
		t_edge = $realtime;
	end

	// ----------------------------------------------------------------
	// burst sequence, one pass per device request
	// ----------------------------------------------------------------
	initial begin
		// selects and address lines are not modelled, so stay negated
		dmack_n_o = 1'b1;
		stop_o = 1'b1;
		rdy_n_o = 1'b1;
		forever begin
			@(posedge hclk_i);
			if (dmarq_i) begin
				@(posedge hclk_i);
				dmack_n_o <= 1'b0;
				t_ack = $realtime;
				t_edge = $realtime;
				rx.delete();
				sp = 1.0e6;
				su = 1.0e6;
				ho = 1.0e6;
				@(posedge hclk_i);
				stop_o <= 1'b0;
				rdy_n_o <= 1'b0;
				t_go = $realtime;
				// a device pause never draws stop; only the bench does
				while (!term || rx.size() == 0) begin
					@(posedge hclk_i);
					if (rx.size() > 0 && rdy_n_o != pause) begin
						rdy_n_o <= pause;
						t_rdy = $realtime;
					end
				end
				rdy_n_o <= 1'b1;
				t_rdy = $realtime;
				repeat (2) @(posedge hclk_i);
				stop_o <= 1'b1;
				t_stop = $realtime;
				while (dmarq_i) @(posedge hclk_i);
				drv = 1'b1;
				repeat (2) @(posedge hclk_i);
				dmack_n_o <= 1'b1;
				@(posedge hclk_i);
				drv = 1'b0;
			end
		end
	end
endmodule : udb_host_model

//--- bench/udb_data_in_tb.sv
// self-checking bench for the data-in burst sender
// assumes the design files and the host model are compiled first
`timescale 1ns/1ns
`include "udb_regs.svh"
module udb_data_in_tb;
	// ----------------------------------------------------------------
	// clocks, pins and bookkeeping
	// ----------------------------------------------------------------
	logic clk = 1'b0, hclk = 1'b0, rst = 1'b1; // core, host clock, reset
	logic [2:0] mode = 3'h0; // transfer mode
	logic xreq = 1'b0, upause = 1'b0, wvalid = 1'b0; // user side
	logic [15:0] wdata = 16'h0000; // word to store
	logic wready, dmarq, dstb, dstb_oe, dd_oe, crc_v, busy; // outputs
	logic dmack_n, stop, rdy_n; // host pins
	logic [15:0] dd, hdd, crc; // bus words
	udb_pkg::udb_word_t exp_q[$]; // words expected at the host
	int bad_count = 0, checks = 0, nexp = 0; // tallies, word target
	int crc_seen = 0; // check word pulses in this burst

	always #5 clk = ~clk;
	// count check word pulses away from the launching edge
	always @(negedge clk) begin
		if (crc_v === 1'b1) begin
			crc_seen++;
		end
	end
	// host clock unrelated in phase to the core clock
	always begin
		#62 hclk = ~hclk;
		#63 hclk = ~hclk;
	end

	udb_data_in dut (.REF_CLK_I(clk), .RST_I(rst), .MODE_I(mode),
		.XFER_REQ_I(xreq), .PAUSE_I(upause), .WR_DATA_I(wdata),
		.WR_VALID_I(wvalid), .WR_READY_O(wready), .DMARQ_O(dmarq),
		.DMACK_N_I(dmack_n), .STOP_I(stop), .HDMARDY_N_I(rdy_n),
		.DSTROBE_O(dstb), .DSTROBE_OE_O(dstb_oe), .DD_I(hdd), .DD_O(dd),
		.DD_OE_O(dd_oe), .CRC_O(crc), .CRC_VALID_O(crc_v), .BUSY_O(busy));
	udb_host_model host (.hclk_i(hclk), .dmarq_i(dmarq), .dstrobe_i(dstb),
		.dstb_oe_i(dstb_oe), .dd_i(dd), .dd_oe_i(dd_oe),
		.dmack_n_o(dmack_n), .stop_o(stop), .rdy_n_o(rdy_n), .dd_o(hdd));

	// ----------------------------------------------------------------
	// compare, wait and verdict helpers
	// ----------------------------------------------------------------
	task automatic print_verdict;
		if (bad_count == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask : print_verdict
	task automatic cmp_w(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : cmp_w
	// a delay in ps must lie inside [lo, hi]
	task automatic cmp_t(input realtime got, input realtime lo, hi);
		checks++;
		if (!(got >= lo && got <= hi)) begin
			bad_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, int'(got),
				int'(lo));
		end
	endtask : cmp_t
	function automatic logic cond(input int k);
		case (k)
			0: return busy === 1'b0;
			default: return host.rx.size() >= nexp;
		endcase
	endfunction : cond
	// bounded wait; running out ends the run as a failure
	task automatic wait_until(input int k);
		int n;
		n = 0;
		while (!cond(k)) begin
			@(posedge clk);
			n++;
			if (n > 20000) begin
				bad_count++;
				print_verdict();
			end
		end
	endtask : wait_until

	// ----------------------------------------------------------------
	// scenarios
	// ----------------------------------------------------------------
	// reset leaves every driver off and the fifo open
	task automatic t_reset;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(negedge clk);
		cmp_w({dmarq, dstb_oe, dd_oe, busy, crc_v, wready}, 16'h0001);
	endtask : t_reset
	// one burst: n words, optional host pause and device pause
	task automatic t_burst(input logic [2:0] m, input int n, input logic hp,
		input logic dp);
		int i, s;
		realtime dvs, cyc;
		case (m)
			3'h1: begin
				dvs = `UDB_T_DVS_M1_PS;
				cyc = `UDB_T_CYC_M1_PS;
			end
			3'h2: begin
				dvs = `UDB_T_DVS_M2_PS;
				cyc = `UDB_T_CYC_M2_PS;
			end
			3'h3: begin
				dvs = `UDB_T_DVS_M3_PS;
				cyc = `UDB_T_CYC_M3_PS;
			end
			3'h4: begin
				dvs = `UDB_T_DVS_M4_PS;
				cyc = `UDB_T_CYC_M4_PS;
			end
			default: begin
				dvs = `UDB_T_DVS_M0_PS;
				cyc = `UDB_T_CYC_M0_PS;
			end
		endcase
		mode <= m;
		host.crc = 16'hc300 ^ 16'(n);
		for (i = 0; i < n; i++) begin
			wdata <= {m, 13'(i)} ^ 16'h5a5a;
			exp_q.push_back({m, 13'(i)} ^ 16'h5a5a);
			wvalid <= 1'b1;
			@(posedge clk);
		end
		// a full fifo refuses the next word
		if (n == 16) begin
			wdata <= 16'hffff;
			@(negedge clk);
			cmp_w(16'(wready), 16'h0000);
			@(posedge clk);
		end
		wvalid <= 1'b0;
		// words of the last burst must not satisfy this burst's waits
		host.rx.delete();
		crc_seen = 0;
		xreq <= 1'b1;
		nexp = 2;
		wait_until(1);
		if (dp) begin
			upause <= 1'b1;
			repeat (10) @(posedge clk);
			s = host.rx.size();
			repeat (100) @(posedge clk);
			cmp_w(16'(host.rx.size()), 16'(s));
			upause <= 1'b0;
		end
		if (hp) begin
			host.pause = 1'b1;
			repeat (30) @(posedge clk);
			s = host.rx.size();
			repeat (100) @(posedge clk);
			cmp_w(16'(host.rx.size()), 16'(s));
			host.pause = 1'b0;
		end
		nexp = n;
		wait_until(1);
		xreq <= 1'b0;
		host.term = 1'b1;
		wait_until(0);
		host.term = 1'b0;
		cmp_w(crc, host.crc);
		cmp_w(16'(crc_seen), 16'h0001);
		cmp_w(16'(host.rx.size()), 16'(n));
		for (i = 0; i < n; i++) cmp_w(host.rx[i], exp_q[i]);
		cmp_t(host.d_oe * 1000.0, `UDB_T_ZIORDY_PS, 1.0e9);
		cmp_t(host.d_zad * 1000.0, `UDB_T_ZAD_PS, 1.0e9);
		cmp_t(host.su * 1000.0, dvs, 1.0e9);
		cmp_t(host.sp * 1000.0, cyc, 1.0e9);
		cmp_t(host.ho * 1000.0, `UDB_T_DVH_PS, 1.0e9);
		cmp_t(host.d_li * 1000.0, 0.0, `UDB_T_LI_PS);
		cmp_w(16'(host.late), 16'h0000);
		cmp_w(16'(wready), 16'h0001);
		exp_q.delete();
	endtask : t_burst

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		t_reset();
		for (int k = 0; k < 5; k++) t_burst(3'(k), 4 + k, k == 2, k == 3);
		t_burst(3'h4, 16, 1'b1, 1'b1);
		t_reset();
		print_verdict();
	end
endmodule : udb_data_in_tb
